// [hdl/bcd_consts.svh]
// constants for the branch, call and clear decoder
`ifndef BCD_CONSTS_SVH
`define BCD_CONSTS_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define BCD_OFF_CTRL   12'h000
`define BCD_OFF_ACC    12'h004
`define BCD_OFF_FLAGS  12'h008
`define BCD_OFF_BANK   12'h00c
`define BCD_OFF_IDX    12'h010
`define BCD_OFF_SHADOW 12'h014
`define BCD_OFF_INFO   12'h018

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define BCD_CTRL_EXT   0
`define BCD_Z_BIT      2
`define BCD_OV_BIT     3
`define BCD_SH_FLAGS   8
`define BCD_SH_BANK    16
`define BCD_INFO_Q     2
`define BCD_INFO_BUSY  4

// ------------------------------------------------------------
// opcodes and addressing
// ------------------------------------------------------------
`define BCD_OP_OVF     8'he4
`define BCD_OP_ZERO    8'he0
`define BCD_OP_CALL    7'h76
`define BCD_OP_CLR     7'h35
`define BCD_CALL_W2    4'hf
`define BCD_IDX_MAX    8'h5f
`define BCD_ACC_SPLIT  8'h80
`define BCD_SFR_BANK   4'hf
`define BCD_LOW_BANK   4'h0
`define BCD_BR_OFS     21'h000002
`define BCD_RET_OFS    21'h000004

// ------------------------------------------------------------
// q phases
// ------------------------------------------------------------
`define BCD_Q1         2'h0
`define BCD_Q2         2'h1
`define BCD_Q3         2'h2
`define BCD_Q4         2'h3

`endif

// [hdl/bcd_pkg.sv]
// types for the branch, call and clear decoder
package bcd_pkg;

  // ------------------------------------------------------------
  // states and decoded operations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_NOP  = 2'b10
  } bcd_state_e;

  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_OVF  = 3'b001,
    OP_ZERO = 3'b010,
    OP_CALL = 3'b011,
    OP_CLR  = 3'b100
  } bcd_op_e;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  typedef struct packed {
    logic [15:0] word;
    logic [15:0] word2;
    logic [20:0] addr;
  } bcd_ins_s;

  typedef struct packed {
    logic        wr;
    logic [20:0] target;
  } bcd_pc_s;

  typedef struct packed {
    logic        push;
    logic [20:0] data;
  } bcd_stk_s;

  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [11:0] addr;
    logic [7:0]  wdata;
  } bcd_mem_s;

endpackage : bcd_pkg

// [hdl/bcd_addr_calc.sv]
// data-memory address for the clear operand
`include "bcd_consts.svh"

module bcd_addr_calc (
  // operand
  input  wire logic [7:0]  f,
  input  wire logic        a,
  // context
  input  wire logic        ext_en,
  input  wire logic [3:0]  bank,
  input  wire logic [11:0] idx_base,
  // result
  output logic      [11:0] addr,
  output logic             indexed
);

  // ------------------------------------------------------------
  // addressing choice
  // ------------------------------------------------------------
  always_comb begin
    indexed = 1'b0;
    if (a) begin
      addr = {bank, f};
    end else if (ext_en && (f <= `BCD_IDX_MAX)) begin
      addr    = idx_base + {`BCD_LOW_BANK, f};
      indexed = 1'b1;
    end else if (f >= `BCD_ACC_SPLIT) begin
      addr = {`BCD_SFR_BANK, f};
    end else begin
      addr = {`BCD_LOW_BANK, f};
    end
  end

endmodule : bcd_addr_calc

// [hdl/bcd_decoder.sv]
// branch, call and clear decoder with apb registers
// Behaviour
// - overflow branch taken only when overflow set
// - target is address plus two plus 2n
// - branch: one cycle, taken adds nop cycle
// - zero branch taken only when zero set
// - call pushes address plus four first
// - save bit copies acc, flags, bank shadows
// - two-word call loads pc bits 20:1
// - call: two cycles, push q3, pc q4
// - clear writes zero, sets zero flag only
// - access bit picks access or selected bank
// - extended mode indexes operands up to 5fh
// - call target spans full 20-bit range
//
// The implementer's own choices: the register addresses and the APB interface to the registers.
`include "bcd_consts.svh"

module bcd_decoder #(
  parameter int AW = 12
) (
  // clock and reset
  input  wire logic             clock,
  input  wire logic             reset,
  // apb slave
  input  wire logic [AW-1:0]    paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  // instruction in
  input  wire logic             ins_valid,
  input  wire bcd_pkg::bcd_ins_s ins,
  output logic                  ins_ready,
  // core side effects
  output bcd_pkg::bcd_pc_s      pc_out,
  output bcd_pkg::bcd_stk_s     stk_out,
  output bcd_pkg::bcd_mem_s     mem_out
);

  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  bcd_pkg::bcd_state_e state_r, state_nxt;
  bcd_pkg::bcd_op_e    op_r, op_nxt, dec_op;
  bcd_pkg::bcd_ins_s   ins_r, ins_nxt;
  bcd_pkg::bcd_pc_s    pc_r, pc_nxt;
  bcd_pkg::bcd_stk_s   stk_r, stk_nxt;
  bcd_pkg::bcd_mem_s   mem_r, mem_nxt;
  logic [1:0]          q_r, q_nxt;
  logic                taken_r, taken_nxt;
  logic                ext_r, ext_nxt;
  logic [7:0]          acc_r, acc_nxt, ws_r, ws_nxt;
  logic [4:0]          flags_r, flags_nxt, fs_r, fs_nxt;
  logic [3:0]          bank_r, bank_nxt, bs_r, bs_nxt;
  logic [11:0]         idx_r, idx_nxt;
  logic [31:0]         prdata_r, prdata_nxt;
  logic [11:0]         clr_addr;
  logic                clr_indexed;
  logic [20:0]         br_tgt;
  logic                z_set, save_ev, wr_en, hit;

  // ------------------------------------------------------------
  // decode
  // ------------------------------------------------------------
  always_comb begin
    dec_op = bcd_pkg::OP_NONE;
    if (ins.word[15:8] == `BCD_OP_OVF) begin
      dec_op = bcd_pkg::OP_OVF;
    end else if (ins.word[15:8] == `BCD_OP_ZERO) begin
      dec_op = bcd_pkg::OP_ZERO;
    end else if (ins.word[15:9] == `BCD_OP_CALL && ins.word2[15:12] == `BCD_CALL_W2) begin
      dec_op = bcd_pkg::OP_CALL;
    end else if (ins.word[15:9] == `BCD_OP_CLR) begin
      dec_op = bcd_pkg::OP_CLR;
    end
  end

  bcd_addr_calc u_addr (
    .f        (ins.word[7:0]),
    .a        (ins.word[8]),
    .ext_en   (ext_r),
    .bank     (bank_r),
    .idx_base (idx_r),
    .addr     (clr_addr),
    .indexed  (clr_indexed)
  );

  assign br_tgt = ins_r.addr + `BCD_BR_OFS + {{12{ins_r.word[7]}}, ins_r.word[7:0], 1'b0};

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    state_nxt     = state_r;
    q_nxt         = q_r;
    op_nxt        = op_r;
    ins_nxt       = ins_r;
    taken_nxt     = taken_r;
    pc_nxt        = pc_r;
    pc_nxt.wr     = 1'b0;
    stk_nxt       = stk_r;
    stk_nxt.push  = 1'b0;
    mem_nxt       = mem_r;
    mem_nxt.rd    = 1'b0;
    mem_nxt.wr    = 1'b0;
    unique case (state_r)
      bcd_pkg::ST_IDLE: begin
        if (ins_valid) begin
          ins_nxt   = ins;
          op_nxt    = dec_op;
          state_nxt = bcd_pkg::ST_EXEC;
          q_nxt     = `BCD_Q2;
          if (dec_op == bcd_pkg::OP_CLR) begin
            mem_nxt.rd   = 1'b1;
            mem_nxt.addr = clr_addr;
          end
        end
      end
      bcd_pkg::ST_EXEC: begin
        q_nxt = q_r + 2'h1;
        if (q_r == `BCD_Q2 && op_r == bcd_pkg::OP_CALL) begin
          stk_nxt.push = 1'b1;
          stk_nxt.data = ins_r.addr + `BCD_RET_OFS;
        end
        if (q_r == `BCD_Q3) begin
          if ((op_r == bcd_pkg::OP_OVF && flags_r[`BCD_OV_BIT]) ||
              (op_r == bcd_pkg::OP_ZERO && flags_r[`BCD_Z_BIT])) begin
            pc_nxt.wr     = 1'b1;
            pc_nxt.target = br_tgt;
            taken_nxt     = 1'b1;
          end
          if (op_r == bcd_pkg::OP_CALL) begin
            pc_nxt.wr     = 1'b1;
            pc_nxt.target = {ins_r.word2[11:0], ins_r.word[7:0], 1'b0};
            taken_nxt     = 1'b1;
          end
          if (op_r == bcd_pkg::OP_CLR) begin
            mem_nxt.wr    = 1'b1;
            mem_nxt.wdata = 8'h00;
          end
        end
        if (q_r == `BCD_Q4) begin
          state_nxt = taken_r ? bcd_pkg::ST_NOP : bcd_pkg::ST_IDLE;
          q_nxt     = `BCD_Q1;
        end
      end
      bcd_pkg::ST_NOP: begin
        q_nxt = q_r + 2'h1;
        if (q_r == `BCD_Q4) begin
          state_nxt = bcd_pkg::ST_IDLE;
          taken_nxt = 1'b0;
        end
      end
      default: begin
        state_nxt = bcd_pkg::ST_IDLE;
        q_nxt     = `BCD_Q1;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_r <= bcd_pkg::ST_IDLE;
      q_r     <= `BCD_Q1;
      op_r    <= bcd_pkg::OP_NONE;
      ins_r   <= '0;
      taken_r <= 1'b0;
      pc_r    <= '0;
      stk_r   <= '0;
      mem_r   <= '0;
    end else begin
      state_r <= state_nxt;
      q_r     <= q_nxt;
      op_r    <= op_nxt;
      ins_r   <= ins_nxt;
      taken_r <= taken_nxt;
      pc_r    <= pc_nxt;
      stk_r   <= stk_nxt;
      mem_r   <= mem_nxt;
    end
  end

  assign ins_ready = (state_r == bcd_pkg::ST_IDLE);
  assign pc_out    = pc_r;
  assign stk_out   = stk_r;
  assign mem_out   = mem_r;

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  assign z_set   = state_r == bcd_pkg::ST_EXEC && q_r == `BCD_Q4 && op_r == bcd_pkg::OP_CLR;
  assign save_ev = stk_r.push && ins_r.word[8];
  assign wr_en   = psel && penable && pwrite;

  always_comb begin
    hit        = 1'b1;
    prdata_nxt = prdata_r;
    ext_nxt    = ext_r;
    acc_nxt    = acc_r;
    flags_nxt  = flags_r;
    bank_nxt   = bank_r;
    idx_nxt    = idx_r;
    ws_nxt     = ws_r;
    fs_nxt     = fs_r;
    bs_nxt     = bs_r;
    unique case (paddr)
      `BCD_OFF_CTRL, `BCD_OFF_ACC, `BCD_OFF_FLAGS, `BCD_OFF_BANK,
      `BCD_OFF_IDX, `BCD_OFF_SHADOW, `BCD_OFF_INFO: hit = 1'b1;
      default: hit = 1'b0;
    endcase
    if (psel && !penable) begin
      prdata_nxt = 32'h0000_0000;
      unique case (paddr)
        `BCD_OFF_CTRL:   prdata_nxt[`BCD_CTRL_EXT] = ext_r;
        `BCD_OFF_ACC:    prdata_nxt[7:0] = acc_r;
        `BCD_OFF_FLAGS:  prdata_nxt[4:0] = flags_r;
        `BCD_OFF_BANK:   prdata_nxt[3:0] = bank_r;
        `BCD_OFF_IDX:    prdata_nxt[11:0] = idx_r;
        `BCD_OFF_SHADOW: begin
          prdata_nxt[7:0]                      = ws_r;
          prdata_nxt[`BCD_SH_FLAGS +: 5]       = fs_r;
          prdata_nxt[`BCD_SH_BANK +: 4]        = bs_r;
        end
        `BCD_OFF_INFO: begin
          prdata_nxt[1:0]                      = state_r;
          prdata_nxt[`BCD_INFO_Q +: 2]         = q_r;
          prdata_nxt[`BCD_INFO_BUSY]           = !ins_ready;
        end
        default: prdata_nxt = 32'h0000_0000;
      endcase
    end
    if (wr_en) begin
      unique case (paddr)
        `BCD_OFF_CTRL:  ext_nxt   = pwdata[`BCD_CTRL_EXT];
        `BCD_OFF_ACC:   acc_nxt   = pwdata[7:0];
        `BCD_OFF_FLAGS: flags_nxt = pwdata[4:0];
        `BCD_OFF_BANK:  bank_nxt  = pwdata[3:0];
        `BCD_OFF_IDX:   idx_nxt   = pwdata[11:0];
        default:        hit       = hit;
      endcase
    end
    if (z_set) begin
      flags_nxt[`BCD_Z_BIT] = 1'b1;
    end
    if (save_ev) begin
      ws_nxt = acc_r;
      fs_nxt = flags_r;
      bs_nxt = bank_r;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      prdata_r <= '0;
      ext_r    <= 1'b0;
      acc_r    <= '0;
      flags_r  <= '0;
      bank_r   <= '0;
      idx_r    <= '0;
      ws_r     <= '0;
      fs_r     <= '0;
      bs_r     <= '0;
    end else begin
      prdata_r <= prdata_nxt;
      ext_r    <= ext_nxt;
      acc_r    <= acc_nxt;
      flags_r  <= flags_nxt;
      bank_r   <= bank_nxt;
      idx_r    <= idx_nxt;
      ws_r     <= ws_nxt;
      fs_r     <= fs_nxt;
      bs_r     <= bs_nxt;
    end
  end

  assign prdata  = prdata_r;
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);

  logic in_q3;
  assign in_q3 = state_r == bcd_pkg::ST_EXEC && q_r == `BCD_Q3;

  ovf_branch_a: assert property (
    in_q3 && op_r == bcd_pkg::OP_OVF |=> pc_r.wr == $past(flags_r[`BCD_OV_BIT]))
    else $error("overflow branch decision wrong");
  br_target_a: assert property (
    pc_r.wr && (op_r == bcd_pkg::OP_OVF || op_r == bcd_pkg::OP_ZERO)
    |-> pc_r.target == ins_r.addr + 21'h2 + {{12{ins_r.word[7]}}, ins_r.word[7:0], 1'b0})
    else $error("branch target wrong");
  br_cycles_a: assert property (
    pc_r.wr |-> q_r == `BCD_Q4 ##1 (state_r == bcd_pkg::ST_NOP)[*4] ##1 state_r == bcd_pkg::ST_IDLE)
    else $error("taken branch length wrong");
  zero_branch_a: assert property (
    in_q3 && op_r == bcd_pkg::OP_ZERO |=> pc_r.wr == $past(flags_r[`BCD_Z_BIT]))
    else $error("zero branch decision wrong");
  call_push_a: assert property (
    stk_r.push |-> op_r == bcd_pkg::OP_CALL && in_q3 && stk_r.data == ins_r.addr + 21'h4)
    else $error("return push wrong");
  shadow_keep_a: assert property (
    !$stable(ws_r) || !$stable(fs_r) || !$stable(bs_r) |-> $past(save_ev))
    else $error("shadow changed without save");
  call_target_a: assert property (
    pc_r.wr && op_r == bcd_pkg::OP_CALL |-> pc_r.target == {ins_r.word2[11:0], ins_r.word[7:0], 1'b0})
    else $error("call target wrong");
  call_order_a: assert property (
    stk_r.push |=> pc_r.wr ##1 (state_r == bcd_pkg::ST_NOP)[*4])
    else $error("call sequence wrong");
  clr_zero_a: assert property (
    mem_r.wr |-> mem_r.wdata == 8'h00 ##1 flags_r[`BCD_Z_BIT])
    else $error("clear did not zero or set flag");
  clr_bank_a: assert property (
    mem_r.rd && ins_r.word[8] |-> mem_r.addr == {$past(bank_r), ins_r.word[7:0]})
    else $error("banked clear address wrong");
  idx_mode_a: assert property (
    mem_r.rd && !ins_r.word[8] && $past(ext_r) && ins_r.word[7:0] <= 8'h5f
    |-> mem_r.addr == $past(idx_r) + {4'h0, ins_r.word[7:0]})
    else $error("indexed clear address wrong");
  flags_keep_a: assert property (
    state_r != bcd_pkg::ST_IDLE && op_r != bcd_pkg::OP_CLR && !wr_en |=> $stable(flags_r))
    else $error("flags changed by branch or call");
  clr_phase_a: assert property (
    mem_r.rd |-> q_r == `BCD_Q2 ##2 mem_r.wr)
    else $error("clear phases wrong");

  ovf_taken_c:  cover property (pc_r.wr && op_r == bcd_pkg::OP_OVF);
  zero_skip_c:  cover property (in_q3 && op_r == bcd_pkg::OP_ZERO && !flags_r[`BCD_Z_BIT]);
  call_save_c:  cover property (save_ev);
  clr_index_c:  cover property (mem_r.wr && ext_r && !ins_r.word[8]);

endmodule : bcd_decoder

// [dv/test_branch_call_clear_decode.sv]
// self-checking testbench for the branch, call and clear decoder
`include "bcd_consts.svh"

module test_branch_call_clear_decode;
  timeunit 1ns;
  timeprecision 1ns;

  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic              clock;
  logic              reset;
  logic [11:0]       paddr;
  logic              psel;
  logic              penable;
  logic              pwrite;
  logic [31:0]       pwdata;
  logic [31:0]       prdata;
  logic              pready;
  logic              pslverr;
  logic              ins_valid;
  bcd_pkg::bcd_ins_s ins;
  logic              ins_ready;
  bcd_pkg::bcd_pc_s  pc_out;
  bcd_pkg::bcd_stk_s stk_out;
  bcd_pkg::bcd_mem_s mem_out;
  int                errors;
  int                tests_run;
  logic              ext_m;
  logic [7:0]        acc_m;
  logic [4:0]        flags_m;
  logic [3:0]        bank_m;
  logic [11:0]       idx_m;
  logic [31:0]       shadow_m;
  logic [7:0]        rd_m;
  logic [7:0]        wr_m;
  logic [7:0]        push_m;
  logic [7:0]        pcw_m;
  logic [31:0]       rdy_k;
  logic [20:0]       pc_t;
  logic [20:0]       stk_d;
  logic [11:0]       mem_a;
  logic [7:0]        mem_wd;

  bcd_decoder #(.AW(12)) bcd_decoder_i (
    .clock(clock), .reset(reset), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .ins_valid(ins_valid),
    .ins(ins), .ins_ready(ins_ready), .pc_out(pc_out), .stk_out(stk_out), .mem_out(mem_out)
  );

  always #50 clock = ~clock;

  // ------------------------------------------------------------
  // reporting
  // ------------------------------------------------------------
  task automatic finish_test();
    $display("errors %0d tests_run %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : finish_test

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // ------------------------------------------------------------
  // bus and instruction drivers
  // ------------------------------------------------------------
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] rd, output logic err);
    int n;
    @(posedge clock);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic exec(input logic [15:0] w, input logic [15:0] w2, input logic [20:0] a);
    int n;
    @(posedge clock);
    ins_valid <= 1'b1;
    ins       <= {w, w2, a};
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (ins_ready !== 1'b1 && n < 20);
    if (n >= 20) begin
      errors++;
      finish_test();
    end
    ins_valid <= 1'b0;
    {rd_m, wr_m, push_m, pcw_m} = '0;
    rdy_k = 0;
    for (int k = 1; k <= 8; k++) begin
      @(posedge clock);
      if (mem_out.rd === 1'b1) rd_m[k-1] = 1'b1;
      if (mem_out.wr === 1'b1) begin
        wr_m[k-1] = 1'b1;
        mem_a = mem_out.addr;
        mem_wd = mem_out.wdata;
      end
      if (stk_out.push === 1'b1) begin
        push_m[k-1] = 1'b1;
        stk_d = stk_out.data;
      end
      if (pc_out.wr === 1'b1) begin
        pcw_m[k-1] = 1'b1;
        pc_t = pc_out.target;
      end
      if (ins_ready === 1'b1 && rdy_k == 0) rdy_k = k;
    end
  endtask : exec

  // ------------------------------------------------------------
  // expectations
  // ------------------------------------------------------------
  function automatic logic [11:0] exp_addr(input logic [15:0] w);
    if (w[8]) return {bank_m, w[7:0]};
    if (ext_m && w[7:0] <= `BCD_IDX_MAX) return idx_m + {4'h0, w[7:0]};
    return {w[7] ? 4'hf : 4'h0, w[7:0]};
  endfunction : exp_addr

  task automatic set_ctx(input logic e, input logic [7:0] ac, input logic [4:0] fl,
                         input logic [3:0] bk, input logic [11:0] ix);
    logic [31:0] rd;
    logic        err;
    ext_m = e;
    acc_m = ac;
    flags_m = fl;
    bank_m = bk;
    idx_m = ix;
    apb(1'b1, `BCD_OFF_CTRL, {31'h0, e}, rd, err);
    apb(1'b1, `BCD_OFF_ACC, {24'h0, ac}, rd, err);
    apb(1'b1, `BCD_OFF_FLAGS, {27'h0, fl}, rd, err);
    apb(1'b1, `BCD_OFF_BANK, {28'h0, bk}, rd, err);
    apb(1'b1, `BCD_OFF_IDX, {20'h0, ix}, rd, err);
  endtask : set_ctx

  task automatic run(input logic [15:0] w, input logic [15:0] w2, input logic [20:0] a);
    logic        taken;
    logic        is_call;
    logic        is_clr;
    logic [31:0] rd;
    logic        err;
    logic [20:0] exp_pc;
    taken = (w[15:8] == `BCD_OP_OVF && flags_m[`BCD_OV_BIT]) || (w[15:8] == `BCD_OP_ZERO && flags_m[`BCD_Z_BIT]);
    is_call = w[15:9] == `BCD_OP_CALL && w2[15:12] == `BCD_CALL_W2;
    is_clr = w[15:9] == `BCD_OP_CLR;
    exec(w, w2, a);
    check("mem rd", rd_m, is_clr ? 8'h01 : 8'h00);
    check("mem wr", wr_m, is_clr ? 8'h04 : 8'h00);
    check("push", push_m, is_call ? 8'h02 : 8'h00);
    check("pc wr", pcw_m, (taken || is_call) ? 8'h04 : 8'h00);
    check("ready", rdy_k, (taken || is_call) ? 32'h8 : 32'h4);
    exp_pc = a + `BCD_BR_OFS + {{12{w[7]}}, w[7:0], 1'b0};
    if (taken) check("br target", pc_t, exp_pc);
    if (is_call) begin
      check("call target", pc_t, {w2[11:0], w[7:0], 1'b0});
      exp_pc = a + `BCD_RET_OFS;
      check("ret addr", stk_d, exp_pc);
      if (w[8]) shadow_m = {12'h0, bank_m, 3'h0, flags_m, acc_m};
    end
    if (is_clr) begin
      check("clr addr", mem_a, exp_addr(w));
      check("clr data", mem_wd, 8'h00);
      flags_m[`BCD_Z_BIT] = 1'b1;
    end
    apb(1'b0, `BCD_OFF_FLAGS, 32'h0, rd, err);
    check("flags", rd, {27'h0, flags_m});
    apb(1'b0, `BCD_OFF_SHADOW, 32'h0, rd, err);
    check("shadow", rd, shadow_m);
  endtask : run

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [31:0] rd;
    logic        err;
    logic [15:0] w;
    clock = 1'b0;
    reset = 1'b1;
    {psel, penable, pwrite} = 3'h0;
    paddr = 12'h000;
    pwdata = 32'h0;
    ins_valid = 1'b0;
    ins = '0;
    errors = 0;
    tests_run = 0;
    shadow_m = 32'h0;
    void'($urandom(32'hd9104f17));
    repeat (8) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, 12'(4 * i), 32'h0, rd, err);
      check("reset value", {err, rd[30:0]}, 32'h0);
    end
    apb(1'b0, 12'h01c, 32'h0, rd, err);
    check("unmapped", {err, rd[30:0]}, 32'h80000000);
    apb(1'b1, `BCD_OFF_SHADOW, 32'hffffffff, rd, err);
    apb(1'b1, `BCD_OFF_ACC, 32'hffffffff, rd, err);
    apb(1'b0, `BCD_OFF_ACC, 32'h0, rd, err);
    check("acc width", rd, 32'h000000ff);
    set_ctx(1'b0, 8'h5a, 5'h08, 4'h3, 12'h100);
    run(16'he480, 16'h0, 21'h000200);
    run(16'he07f, 16'h0, 21'h000200);
    set_ctx(1'b1, 8'ha5, 5'h14, 4'hc, 12'h7f0);
    run(16'he07f, 16'h0, 21'h1ffffe);
    run(16'he4ff, 16'h0, 21'h000010);
    run(16'hedff, 16'hffff, 21'h000100);
    run(16'hec00, 16'hf000, 21'h1ffffc);
    run(16'hed12, 16'h0123, 21'h000040);
    run(16'h6a5f, 16'h0, 21'h0);
    run(16'h6a60, 16'h0, 21'h0);
    run(16'h6bff, 16'h0, 21'h0);
    set_ctx(1'b0, 8'h00, 5'h00, 4'h1, 12'h000);
    run(16'h6a80, 16'h0, 21'h0);
    run(16'h6a05, 16'h0, 21'h0);
    for (int i = 0; i < 40; i++) begin
      set_ctx(1'($urandom), 8'($urandom), 5'($urandom), 4'($urandom), 12'($urandom));
      case ($urandom_range(0, 3))
        0: w = {`BCD_OP_OVF, 8'($urandom)};
        1: w = {`BCD_OP_ZERO, 8'($urandom)};
        2: w = {`BCD_OP_CALL, 9'($urandom)};
        default: w = {`BCD_OP_CLR, 9'($urandom)};
      endcase
      run(w, {`BCD_CALL_W2, 12'($urandom)}, {20'($urandom), 1'b0});
    end
    finish_test();
  end

endmodule : test_branch_call_clear_decode
